/* shared/cpuamd_pkg.sv */
// constants, modes and carriers for the addressing-mode decoder
// What this block does
// - seventeen operand modes in seven groups
// - short forms reach zero page only, except short indexed which reaches 1FE; faster
// - long forms reach all 64 Kbyte
// - memory-to-memory operations use short forms only
// - inherent opcode is one byte, no operand
// - immediate is opcode plus one value byte
// - short direct takes one address byte
// - long direct takes a two-byte address
// - indexed address is unsigned register plus offset
// - no-offset indexed fetches nothing, page zero
// - short indexed takes one byte, reaches 1FE
// - long indexed takes a two-byte offset
// - mask set gives level 3, clear level 0
// - wait idles until interrupt, halt stops oscillator
// - prefixes select second register and indirect forms
// - relative adds signed byte to program counter
// - short indirect reads byte pointer from page zero
package cpuamd_pkg;
	// ****************************************
	// byte codes
	// ****************************************
	localparam logic [7:0] CPUAMD_PFX_Y = 8'h90; // second_reg_prefix
	localparam logic [7:0] CPUAMD_PFX_IY = 8'h91; // indirect_second_prefix
	localparam logic [7:0] CPUAMD_PFX_I = 8'h92; // indirect_prefix
	localparam logic [7:0] CPUAMD_OP_MSET = 8'h9b; // mask_set_op
	localparam logic [7:0] CPUAMD_OP_MCLR = 8'h9a; // mask_clear_op
	localparam logic [7:0] CPUAMD_OP_WFI = 8'h8f; // wait_for_irq_op
	localparam logic [7:0] CPUAMD_OP_HALT = 8'h8e; // oscillator stop
	// ****************************************
	// levels and reset values
	// ****************************************
	localparam logic [1:0] CPUAMD_MASK_HI = 2'b11; // level 3
	localparam logic [1:0] CPUAMD_MASK_LO = 2'b00; // level 0
	localparam logic [1:0] CPUAMD_MASK_RST = 2'b11; // interrupts masked out of reset
	localparam logic [15:0] CPUAMD_ZERO16 = 16'h0000;
	localparam logic [7:0] CPUAMD_ZERO8 = 8'h00;
	// ****************************************
	// modes and states
	// ****************************************
	typedef enum logic [4:0] {
		M_INH = 5'h00, M_IMM = 5'h01, M_DIR_S = 5'h02, M_DIR_L = 5'h03,
		M_IDX_0 = 5'h04, M_IDX_S = 5'h05, M_IDX_L = 5'h06, M_IND_S = 5'h07,
		M_IND_L = 5'h08, M_IIDX_S = 5'h09, M_IIDX_L = 5'h0a, M_REL_D = 5'h0b,
		M_REL_I = 5'h0c, M_BIT_D = 5'h0d, M_BIT_I = 5'h0e, M_BREL_D = 5'h0f,
		M_BREL_I = 5'h10
	} cpuamd_mode_type;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_OPC = 3'b001, S_ARG = 3'b010, S_PTR = 3'b011
	} cpuamd_state_type;
	// result of one decode
	typedef struct packed {
		cpuamd_mode_type mode;
		logic [7:0] opcode;
		logic [7:0] prefix;
		logic use_y;
		logic [2:0] length;
		logic [15:0] ea;
		logic [7:0] imm;
		logic [15:0] target;
		logic [15:0] pc_next;
	} cpuamd_result_type;
	// full state of the decoder
	typedef struct packed {
		cpuamd_state_type st;
		logic [15:0] pc;
		logic [7:0] prefix;
		logic [7:0] opcode;
		cpuamd_mode_type mode;
		logic use_y;
		logic [1:0] arg_left;
		logic [15:0] arg;
		logic [1:0] ptr_left;
		logic [15:0] ptr_addr;
		logic [15:0] ptr;
		logic [2:0] length;
		logic mem_rd;
		logic [15:0] mem_addr;
		logic done;
		logic fin; // done strobe as it leaves the block, a cycle after done
		cpuamd_result_type res;
		logic [1:0] imask;
		logic wait_lp;
		logic halt_lp;
	} cpuamd_regs_type;
endpackage

/* design/cpuamd_decoder.sv */
// addressing-mode decoder and effective-address sequencer
`timescale 1ns/10ps
`default_nettype none
module cpuamd_decoder
	import cpuamd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic start, // begin decode at pc_in
	input wire logic [15:0] pc_in,
	input wire logic [7:0] x_reg, // first offset register
	input wire logic [7:0] y_reg, // second offset register
	input wire logic irq, // wake from wait or halt
	input wire logic mem_ack, // read data valid this cycle
	input wire logic [7:0] mem_rdata,
	output logic mem_rd,
	output logic [15:0] mem_addr,
	output logic busy,
	output logic done,
	output cpuamd_result_type result,
	output logic [1:0] imask,
	output logic wait_lp,
	output logic halt_lp
);
	// ****************************************
	// state
	// ****************************************
	cpuamd_regs_type r_q; // all flip-flops
	cpuamd_regs_type r_d; // their next values
	cpuamd_mode_type dm; // mode of the arriving opcode
	logic dy; // arriving opcode uses second register
	logic [1:0] dargs; // bytes after the opcode
	logic [1:0] dptr; // pointer bytes to read
	logic [7:0] idx; // chosen offset register
	logic [15:0] base; // address before indexing
	logic [7:0] rel; // signed branch offset
	logic [15:0] pcn; // pc after the instruction

	// ****************************************
	// opcode class table
	// ****************************************
	// row by high nibble, widened by the prefix; memory-to-memory rows
	// only have short encodings, so no long form ever comes out of them
	always_comb begin
		dm = M_INH;
		dy = (r_q.prefix == CPUAMD_PFX_Y) || (r_q.prefix == CPUAMD_PFX_IY);
		unique case (mem_rdata[7:4])
			4'h0: dm = (r_q.prefix == CPUAMD_PFX_I) ? M_BREL_I : M_BREL_D;
			4'h1: dm = (r_q.prefix == CPUAMD_PFX_I) ? M_BIT_I : M_BIT_D;
			4'h2: dm = (r_q.prefix == CPUAMD_PFX_I) ? M_REL_I : M_REL_D;
			4'h3: dm = (r_q.prefix == CPUAMD_PFX_I) ? M_IND_S : M_DIR_S;
			4'h4, 4'h5, 4'h8, 4'h9: dm = M_INH;
			4'h6: dm = (r_q.prefix == CPUAMD_PFX_I || r_q.prefix == CPUAMD_PFX_IY) ? M_IIDX_S : M_IDX_S;
			4'h7, 4'hf: dm = M_IDX_0;
			4'ha: dm = M_IMM;
			4'hb: dm = (r_q.prefix == CPUAMD_PFX_I) ? M_IND_S : M_DIR_S;
			4'hc: dm = (r_q.prefix == CPUAMD_PFX_I) ? M_IND_L : M_DIR_L;
			4'hd: dm = (r_q.prefix == CPUAMD_PFX_I || r_q.prefix == CPUAMD_PFX_IY) ? M_IIDX_L : M_IDX_L;
			4'he: dm = (r_q.prefix == CPUAMD_PFX_I || r_q.prefix == CPUAMD_PFX_IY) ? M_IIDX_S : M_IDX_S;
		endcase
	end

	// ****************************************
	// bytes each mode needs
	// ****************************************
	always_comb begin
		dargs = 2'd0;
		dptr = 2'd0;
		unique case (dm)
			M_INH, M_IDX_0: dargs = 2'd0;
			M_IMM, M_DIR_S, M_IDX_S, M_REL_D, M_BIT_D: dargs = 2'd1;
			M_DIR_L, M_IDX_L, M_BREL_D: dargs = 2'd2;
			M_IND_S, M_IIDX_S, M_REL_I, M_BIT_I: begin
				dargs = 2'd1;
				dptr = 2'd1;
			end
			M_IND_L, M_IIDX_L: begin
				dargs = 2'd1;
				dptr = 2'd2; // pointer is a word
			end
			M_BREL_I: begin
				dargs = 2'd2;
				dptr = 2'd1;
			end
		endcase
	end

	// ****************************************
	// effective address arithmetic
	// ****************************************
	always_comb begin
		idx = r_q.use_y ? y_reg : x_reg;
		pcn = r_q.pc;
		rel = r_q.arg[7:0];
		unique case (r_q.mode)
			M_IND_S, M_IND_L, M_IIDX_S, M_IIDX_L, M_BIT_I: base = r_q.ptr;
			M_BREL_D: base = {CPUAMD_ZERO8, r_q.arg[15:8]};
			M_BREL_I: base = r_q.ptr;
			M_DIR_L, M_IDX_L: base = r_q.arg;
			M_IDX_0: base = CPUAMD_ZERO16;
			default: base = {CPUAMD_ZERO8, r_q.arg[7:0]};
		endcase
		if (r_q.mode == M_REL_I) begin
			rel = r_q.ptr[7:0];
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		r_d = r_q;
		r_d.done = 1'b0;
		// done leaves a cycle late so that strobe and published result come out together
		r_d.fin = r_q.done;
		// wake from either low power state on an interrupt
		if (irq) begin
			r_d.wait_lp = 1'b0;
			r_d.halt_lp = 1'b0;
		end
		unique case (r_q.st)
			S_IDLE: begin
				// no fetch while the core sleeps
				if (start && !r_q.wait_lp && !r_q.halt_lp) begin
					r_d.st = S_OPC;
					r_d.pc = pc_in;
					r_d.prefix = CPUAMD_ZERO8;
					r_d.length = 3'd0;
					r_d.arg = CPUAMD_ZERO16;
					r_d.ptr = CPUAMD_ZERO16;
					r_d.mem_rd = 1'b1;
					r_d.mem_addr = pc_in;
				end
			end
			S_OPC: begin
				if (mem_ack) begin
					r_d.pc = r_q.pc + 16'h0001;
					r_d.mem_addr = r_q.pc + 16'h0001;
					r_d.length = r_q.length + 3'd1;
					// only one prefix is honoured; a second one is taken as opcode
					if (r_q.prefix == CPUAMD_ZERO8 && (mem_rdata == CPUAMD_PFX_Y ||
							mem_rdata == CPUAMD_PFX_IY || mem_rdata == CPUAMD_PFX_I)) begin
						r_d.prefix = mem_rdata;
					end else begin
						r_d.opcode = mem_rdata;
						r_d.mode = dm;
						r_d.use_y = dy;
						r_d.arg_left = dargs;
						r_d.ptr_left = dptr;
						if (dargs == 2'd0) begin
							r_d.mem_rd = 1'b0;
							r_d.st = S_IDLE;
							r_d.done = 1'b1;
						end else begin
							r_d.st = S_ARG;
						end
						// control effects of single-byte operations
						if (dm == M_INH) begin
							if (mem_rdata == CPUAMD_OP_MSET) begin
								r_d.imask = CPUAMD_MASK_HI;
							end
							if (mem_rdata == CPUAMD_OP_MCLR) begin
								r_d.imask = CPUAMD_MASK_LO;
							end
							if (mem_rdata == CPUAMD_OP_WFI) begin
								r_d.wait_lp = 1'b1;
							end
							if (mem_rdata == CPUAMD_OP_HALT) begin
								r_d.halt_lp = 1'b1;
							end
						end
					end
				end
			end
			S_ARG: begin
				if (mem_ack) begin
					// bytes arrive most significant first
					r_d.arg = {r_q.arg[7:0], mem_rdata};
					r_d.pc = r_q.pc + 16'h0001;
					r_d.mem_addr = r_q.pc + 16'h0001;
					r_d.length = r_q.length + 3'd1;
					r_d.arg_left = r_q.arg_left - 2'd1;
					if (r_q.arg_left == 2'd1) begin
						if (r_q.ptr_left == 2'd0) begin
							r_d.mem_rd = 1'b0;
							r_d.st = S_IDLE;
							r_d.done = 1'b1;
						end else begin
							// pointer sits in page zero; for bit-relative the first byte is it
							r_d.ptr_addr = (r_q.mode == M_BREL_I) ? {CPUAMD_ZERO8, r_q.arg[7:0]}
								: {CPUAMD_ZERO8, mem_rdata};
							r_d.mem_addr = r_d.ptr_addr;
							r_d.st = S_PTR;
						end
					end
				end
			end
			S_PTR: begin
				if (mem_ack) begin
					r_d.ptr = {r_q.ptr[7:0], mem_rdata};
					r_d.ptr_addr = r_q.ptr_addr + 16'h0001;
					r_d.mem_addr = r_q.ptr_addr + 16'h0001;
					r_d.ptr_left = r_q.ptr_left - 2'd1;
					if (r_q.ptr_left == 2'd1) begin
						r_d.mem_rd = 1'b0;
						r_d.st = S_IDLE;
						r_d.done = 1'b1;
					end
				end
			end
			default: begin
				r_d.st = S_IDLE;
				r_d.mem_rd = 1'b0;
			end
		endcase
		// publish the result from the values settled this cycle
		if (r_q.done) begin
			r_d.res.mode = r_q.mode;
			r_d.res.opcode = r_q.opcode;
			r_d.res.prefix = r_q.prefix;
			r_d.res.use_y = r_q.use_y;
			r_d.res.length = r_q.length;
			r_d.res.imm = r_q.arg[7:0];
			r_d.res.pc_next = pcn;
			r_d.res.target = pcn + {{8{rel[7]}}, rel};
			// short indexed reaches 1FE: the add carries into bit 8
			if (r_q.mode inside {M_IDX_0, M_IDX_S, M_IDX_L, M_IIDX_S, M_IIDX_L}) begin
				r_d.res.ea = base + {CPUAMD_ZERO8, idx};
			end else begin
				r_d.res.ea = base;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r_q <= '0;
			r_q.imask <= CPUAMD_MASK_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// ****************************************
	// outputs straight from flip-flops
	// ****************************************
	assign mem_rd = r_q.mem_rd;
	assign mem_addr = r_q.mem_addr;
	assign busy = r_q.mem_rd;
	assign done = r_q.fin;
	assign result = r_q.res;
	assign imask = r_q.imask;
	assign wait_lp = r_q.wait_lp;
	assign halt_lp = r_q.halt_lp;
endmodule
`default_nettype wire

/* test/cpuamd_properties.sv */
// assertion checker for the addressing-mode decoder
`timescale 1ns/10ps
`default_nettype none
module cpuamd_checker
	import cpuamd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] x_reg,
	input wire logic [7:0] y_reg,
	input wire logic irq,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic busy,
	input wire logic done,
	input wire cpuamd_result_type result,
	input wire logic [1:0] imask,
	input wire logic wait_lp,
	input wire logic halt_lp
);
	// ****************************************
	// properties, one clock domain
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_busy_rd: assert property (busy == mem_rd)
		else $error("busy differs from read strobe");
	a_addr_hold: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
		else $error("read dropped or moved before ack");
	a_mask_set: assert property (done && result.opcode == CPUAMD_OP_MSET |->
		imask == CPUAMD_MASK_HI)
		else $error("mask not at level 3");
	a_mask_clr: assert property (done && result.opcode == CPUAMD_OP_MCLR |->
		imask == CPUAMD_MASK_LO)
		else $error("mask not at level 0");
	a_inh_len: assert property (done && result.mode == M_INH |->
		result.length == (result.prefix == 8'h00 ? 3'h1 : 3'h2))
		else $error("inherent length wrong");
	a_imm_len: assert property (done && result.mode == M_IMM |->
		result.length == (result.prefix == 8'h00 ? 3'h2 : 3'h3))
		else $error("immediate length wrong");
	a_idx0_ea: assert property (done && result.mode == M_IDX_0 |->
		result.ea == {8'h00, result.use_y ? y_reg : x_reg})
		else $error("no-offset address wrong");
	a_dir_page: assert property (done && result.mode == M_DIR_S |-> result.ea[15:8] == 8'h00)
		else $error("short direct left page zero");
	a_rel_tgt: assert property (done && result.mode == M_REL_D |->
		result.target == result.pc_next + {{8{result.imm[7]}}, result.imm})
		else $error("relative target wrong");
	a_wake_irq: assert property ($fell(wait_lp) || $fell(halt_lp) |-> $past(irq))
		else $error("woke without interrupt");
	a_short_page: assert property (done &&
		result.mode inside {M_BIT_D, M_BIT_I, M_BREL_D, M_BREL_I, M_IND_S} |-> result.ea[15:8] == 8'h00)
		else $error("memory operation left page zero");
	c_ind_long: cover property (done && result.mode == M_IND_L);
	c_rel: cover property (done && result.mode == M_REL_D);
	c_sleep: cover property (wait_lp && irq);
	c_bit_rel: cover property (done && result.mode == M_BREL_I);
endmodule
bind cpuamd_decoder cpuamd_checker chk (.sys_clk(sys_clk), .nrst(nrst), .start(start), .pc_in(pc_in),
	.x_reg(x_reg), .y_reg(y_reg), .irq(irq), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
	.mem_addr(mem_addr), .busy(busy), .done(done), .result(result), .imask(imask), .wait_lp(wait_lp),
	.halt_lp(halt_lp));
`default_nettype wire

/* test/cpuamd_mem_model.sv */
// program and data memory answering the decoder's byte reads
`timescale 1ns/10ps
`default_nettype none
module cpuamd_mem_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic slow, // adds two wait cycles per byte
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535]; // filled by the bench
	logic [1:0] wait_q;
	// ack only once the read already stands; data toggles when idle and holds during wait cycles
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mem_ack <= 1'b0;
			mem_rdata <= 8'h5a;
			wait_q <= 2'h0;
		end else if (mem_rd && !mem_ack && wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
		end else if (mem_rd && !mem_ack) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr];
			wait_q <= slow ? 2'h2 : 2'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the addressing-mode decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import cpuamd_pkg::*;
	logic sys_clk = 0, nrst = 0, start = 0, irq = 0, slow = 0, mem_rd, mem_ack, busy, done, wait_lp, halt_lp;
	logic [15:0] pc_in = 16'h0000, mem_addr;
	logic [7:0] x_reg = 8'h00, y_reg = 8'h00, mem_rdata;
	logic [1:0] imask;
	cpuamd_result_type result;
	logic [31:0] seed = 32'h0000_0033;
	int fails = 0, cmp_count = 0, cycles = 0;
	// prefix and opcode of every case; memory-to-memory rows 0, 1, 3 and 6 included
	logic [15:0] tab [28] = '{16'h009b, 16'h009a, 16'h00a6, 16'h00b6, 16'h00c6, 16'h00d6, 16'h00e6, 16'h00f6,
		16'h92b6, 16'h92c6, 16'h92e6, 16'h91d6, 16'h90f6, 16'h0020, 16'h9220, 16'h008f, 16'h008e, 16'h0003,
		16'h9203, 16'h0011, 16'h9211, 16'h003a, 16'h923a, 16'h006c, 16'h926c, 16'h916c, 16'h0048, 16'h92d6};
	cpuamd_decoder uut (.sys_clk(sys_clk), .nrst(nrst), .start(start), .pc_in(pc_in), .x_reg(x_reg), .y_reg(y_reg),
		.irq(irq), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr), .busy(busy),
		.done(done), .result(result), .imask(imask), .wait_lp(wait_lp), .halt_lp(halt_lp));
	cpuamd_mem_model m (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	always #12.5 sys_clk = ~sys_clk;
	// hang guard: the whole run needs well under two thousand cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// one instruction: lay it out, run it, compare with the reference model
	task automatic run_case(input logic [15:0] code);
		logic [31:0] t;
		logic [7:0] pf, op, b1, b2, r, p8;
		logic [15:0] pc, w, ea, pn;
		logic ind;
		cpuamd_mode_type em;
		int n, k;
		pf = code[15:8];
		op = code[7:0];
		t = xs();
		pc = {1'b1, t[14:0]};
		b1 = t[23:16];
		b2 = t[31:24];
		t = xs();
		m.mem[{8'h00, b1}] = t[31:24];
		m.mem[{8'h00, b1} + 16'h0001] = t[23:16];
		k = (pf != 8'h00) ? 1 : 0;
		if (k == 1) m.mem[pc] = pf;
		m.mem[pc + k[15:0]] = op;
		m.mem[pc + k[15:0] + 16'h0001] = b1;
		m.mem[pc + k[15:0] + 16'h0002] = b2;
		@(negedge sys_clk);
		x_reg = t[7:0];
		y_reg = t[15:8];
		slow = t[16];
		start = 1'b1;
		pc_in = pc;
		@(negedge sys_clk);
		start = 1'b0;
		for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge sys_clk);
		r = (pf == 8'h90 || pf == 8'h91) ? y_reg : x_reg;
		// the second-register indirect prefix only turns indexed rows indirect
		ind = (pf == 8'h92) || (pf == 8'h91 && op[7:4] inside {4'h6, 4'hd, 4'he});
		p8 = m.mem[{8'h00, b1}];
		w = {p8, t[23:16]};
		case (op[7:4])
			4'h1, 4'h2, 4'h3, 4'h6, 4'ha, 4'hb, 4'he: n = 1;
			4'hc, 4'hd: n = ind ? 1 : 2;
			4'h0: n = 2;
			default: n = 0;
		endcase
		// expected mode by row; memory-to-memory rows never give a long form
		case (op[7:4])
			4'h0: em = ind ? M_BREL_I : M_BREL_D;
			4'h1: em = ind ? M_BIT_I : M_BIT_D;
			4'h2: em = ind ? M_REL_I : M_REL_D;
			4'h3, 4'hb: em = ind ? M_IND_S : M_DIR_S;
			4'h6, 4'he: em = ind ? M_IIDX_S : M_IDX_S;
			4'h7, 4'hf: em = M_IDX_0;
			4'ha: em = M_IMM;
			4'hc: em = ind ? M_IND_L : M_DIR_L;
			4'hd: em = ind ? M_IIDX_L : M_IDX_L;
			default: em = M_INH;
		endcase
		pn = pc + 16'((pf != 8'h00) + 1 + n);
		check("done", {15'h0000, done}, 16'h0001);
		check("code", {result.prefix, result.opcode}, code);
		check("mode", {11'h000, result.mode}, {11'h000, em});
		check("use_y", {15'h0000, result.use_y}, {15'h0000, pf == 8'h90 || pf == 8'h91});
		check("length", {13'h0000, result.length}, pn - pc);
		check("pc_next", result.pc_next, pn);
		case (op[7:4])
			4'h0, 4'h1, 4'h3, 4'hb: ea = ind ? {8'h00, p8} : {8'h00, b1};
			4'hc: ea = ind ? w : {b1, b2};
			4'hd: ea = (ind ? w : {b1, b2}) + {8'h00, r};
			4'h6, 4'he: ea = (ind ? {8'h00, p8} : {8'h00, b1}) + {8'h00, r};
			default: ea = {8'h00, r};
		endcase
		if (!(op[7:4] inside {4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha}))
			check("ea", result.ea, ea);
		if (op[7:4] == 4'ha) check("imm", {8'h00, result.imm}, {8'h00, b1});
		if (op[7:4] == 4'h2)
			check("target", result.target, pn + {{8{ind ? p8[7] : b1[7]}}, ind ? p8 : b1});
		if (op[7:4] == 4'h0) check("bit target", result.target, pn + {{8{b2[7]}}, b2});
		if (op[7:4] == 4'h9) check("imask", {14'h0000, imask}, op[0] ? 16'h0003 : 16'h0000);
		if (op[7:4] == 4'h8) begin
			check("sleep", {14'h0000, halt_lp, wait_lp}, op[0] ? 16'h0001 : 16'h0002);
			start = 1'b1;
			@(negedge sys_clk);
			start = 1'b0;
			repeat (3) @(negedge sys_clk);
			check("asleep read", {15'h0000, mem_rd}, 16'h0000);
			irq = 1'b1;
			@(negedge sys_clk);
			irq = 1'b0;
			check("woken", {14'h0000, halt_lp, wait_lp}, 16'h0000);
		end
		$display("test %h done", code);
	endtask
	initial begin
		repeat (6) @(negedge sys_clk);
		nrst = 1'b1;
		check("reset mask", {14'h0000, imask}, 16'h0003);
		for (int i = 0; i < 56; i++) run_case(tab[i % 28]);
		// reset in mid-decode: the read must drop at once and the mask return to level 3
		@(negedge sys_clk);
		start = 1'b1;
		pc_in = 16'h8000;
		@(negedge sys_clk);
		start = 1'b0;
		nrst = 1'b0;
		@(negedge sys_clk);
		check("reset read", {15'h0000, busy}, 16'h0000);
		check("reset done", {15'h0000, done}, 16'h0000);
		check("reset mask again", {14'h0000, imask}, 16'h0003);
		nrst = 1'b1;
		$display("test mid-run reset done");
		run_case(tab[21]);
		report_and_stop();
	end
endmodule
`default_nettype wire
